// *** crsd_map.svh ***
// constants of the compact register specifier decoder
// assumes: included by name from the design modules
`ifndef CRSD_MAP_SVH
`define CRSD_MAP_SVH
`define CRSD_GPR_ZERO 5'h00
`define CRSD_GPR_S0 5'h10
`define CRSD_GPR_S1 5'h11
`define CRSD_GPR_GLOBAL_POINTER 5'h1c
`define CRSD_GPR_STACK_POINTER 5'h1d
`define CRSD_GPR_RETURN_ADDRESS 5'h1f
`define CRSD_SHAMT_ZERO_CODE 3'h0
`define CRSD_SHAMT_MAX 4'h8
`endif

// *** crsd_pkg.sv ***
// types of the compact register specifier decoder
// assumes: nothing beyond the constants header
package crsd_pkg;
   // register set picked for a 3-bit specifier
   typedef enum logic [1:0] {
      CRSD_SET_GENERAL,
      CRSD_SET_STORE_SRC,
      CRSD_SET_NONE
   } crsd_set_type;
   // implicit register a compact instruction may name
   typedef enum logic [2:0] {
      CRSD_IMP_NONE,
      CRSD_IMP_GLOBAL_POINTER,
      CRSD_IMP_STACK_POINTER,
      CRSD_IMP_RETURN_ADDRESS
   } crsd_imp_type;
   // source that replaces a general register operand
   typedef enum logic [1:0] {
      CRSD_SRC_GPR,
      CRSD_SRC_PC,
      CRSD_SRC_UPPER,
      CRSD_SRC_BOTTOM
   } crsd_src_type;
endpackage

// *** crsd_spec_map.sv ***
// one 3-bit specifier into a 5-bit register index
// assumes: set select and code are stable in the same cycle
`timescale 1ns/1ns
`include "crsd_map.svh"
module crsd_spec_map (
   input wire logic [2:0] code,
   input wire crsd_pkg::crsd_set_type set_sel,
   output logic [4:0] gpr_idx
);
   always_comb begin
      gpr_idx = {2'h0, code};
      case (set_sel)
         crsd_pkg::CRSD_SET_GENERAL: begin
            if (code == 3'h0) begin
               gpr_idx = `CRSD_GPR_S0; // [RULE2]
            end else if (code == 3'h1) begin
               gpr_idx = `CRSD_GPR_S1; // [RULE2]
            end
         end
         crsd_pkg::CRSD_SET_STORE_SRC: begin
            if (code == 3'h0) begin
               gpr_idx = `CRSD_GPR_ZERO; // [RULE3]
            end else if (code == 3'h1) begin
               gpr_idx = `CRSD_GPR_S1; // [RULE3]
            end
         end
         default: begin
            gpr_idx = {2'h0, code};
         end
      endcase
   end
endmodule

// *** crsd_decoder.sv ***
// register specifier decode for compact 16-bit instructions
// assumes: fields come from the decode stage in the cycle they are used;
// clock and reset only serve the checking logic beside the decode path
`timescale 1ns/1ns
`include "crsd_map.svh"
// Function
// RULE1: a 3-bit specifier reaches just 8 of the 32 general registers.
// RULE2: general set maps code 0 to 16, 1 to 17, and 2..7 unchanged.
// RULE3: store source set maps code 0 to 0, 1 to 17, and 2..7 unchanged.
// RULE4: 5-bit specifiers in compact forms pass through as the index.
// RULE5: implicit global, stack and return registers give 28, 29 and 31.
// RULE6: the pc relative add immediate may take the program counter.
// RULE7: upper and bottom words of mul/div are implicit move-from sources.
// RULE8: compact shifts turn a 3-bit field into an amount of 1 to 8.
// RULE9: the whole translation is combinational, same cycle as the word.
module crsd_decoder #(
   parameter int NUM_PORTS = 3
) (
   input wire logic ref_clk,
   input wire logic rstn,
   input wire logic [2:0] spec_code [NUM_PORTS],
   input wire crsd_pkg::crsd_set_type spec_set [NUM_PORTS],
   input wire logic [4:0] wide_spec,
   input wire logic wide_spec_en,
   input wire crsd_pkg::crsd_imp_type implicit_sel,
   input wire logic pc_relative_add_immediate,
   input wire logic move_from_upper,
   input wire logic move_from_bottom,
   input wire logic [2:0] shift_code,
   output logic [4:0] spec_idx [NUM_PORTS],
   output logic [4:0] alt_idx,
   output logic alt_valid,
   output crsd_pkg::crsd_src_type src_kind,
   output logic [3:0] shift_amount
);
   genvar gi;
   generate
      for (gi = 0; gi < NUM_PORTS; gi++) begin : g_spec
         // only 8 indices reachable per set [RULE1]
         crsd_spec_map u_map (
            .code(spec_code[gi]),
            .set_sel(spec_set[gi]),
            .gpr_idx(spec_idx[gi])
         );
      end
   endgenerate

   // no state here: indices ready in the cycle of the word [RULE9]
   always_comb begin
      alt_idx = 5'h00;
      alt_valid = 1'b0;
      case (implicit_sel)
         crsd_pkg::CRSD_IMP_GLOBAL_POINTER: begin
            alt_idx = `CRSD_GPR_GLOBAL_POINTER; // [RULE5]
            alt_valid = 1'b1;
         end
         crsd_pkg::CRSD_IMP_STACK_POINTER: begin
            alt_idx = `CRSD_GPR_STACK_POINTER; // [RULE5]
            alt_valid = 1'b1;
         end
         crsd_pkg::CRSD_IMP_RETURN_ADDRESS: begin
            alt_idx = `CRSD_GPR_RETURN_ADDRESS; // [RULE5]
            alt_valid = 1'b1;
         end
         default: begin
            // implicit names win over a wide field of the same word
            if (wide_spec_en) begin
               alt_idx = wide_spec; // [RULE4]
               alt_valid = 1'b1;
            end
         end
      endcase
   end

   // pc beats upper/bottom; upper beats bottom when both are raised
   always_comb begin
      if (pc_relative_add_immediate) begin
         src_kind = crsd_pkg::CRSD_SRC_PC; // [RULE6]
      end else if (move_from_upper) begin
         src_kind = crsd_pkg::CRSD_SRC_UPPER; // [RULE7]
      end else if (move_from_bottom) begin
         src_kind = crsd_pkg::CRSD_SRC_BOTTOM; // [RULE7]
      end else begin
         src_kind = crsd_pkg::CRSD_SRC_GPR;
      end
   end

   // code 0 stands for 8, so no shift of zero can be encoded
   always_comb begin
      if (shift_code == `CRSD_SHAMT_ZERO_CODE) begin
         shift_amount = `CRSD_SHAMT_MAX; // [RULE8]
      end else begin
         shift_amount = {1'b0, shift_code}; // [RULE8]
      end
   end

   // a lagging decode shows as an input step with no output step
   // at the same sampling edge; a registered output would miss it
   sequence s_shift_moved;
      $changed(shift_code);
   endsequence
   sequence s_amount_moved;
      $changed(shift_amount);
   endsequence
   sequence s_wide_moved;
      $changed(wide_spec) && $stable(wide_spec_en) && wide_spec_en
      && $stable(implicit_sel) && implicit_sel == crsd_pkg::CRSD_IMP_NONE;
   endsequence
   sequence s_alt_moved;
      $changed(alt_idx);
   endsequence

   a_gen_low_codes: assert property ( // [RULE2]
      @(posedge ref_clk) disable iff (!rstn)
      spec_set[0] == crsd_pkg::CRSD_SET_GENERAL && spec_code[0] < 3'h2
      |-> spec_idx[0] == {4'h8, spec_code[0][0]})
      else $error("general set low code mapped wrong");
   a_store_low_codes: assert property ( // [RULE3]
      @(posedge ref_clk) disable iff (!rstn)
      spec_set[0] == crsd_pkg::CRSD_SET_STORE_SRC && spec_code[0] < 3'h2
      |-> spec_idx[0] == (spec_code[0][0] ? 5'h11 : 5'h00))
      else $error("store source low code mapped wrong");
   a_high_codes_pass: assert property ( // [RULE1]
      @(posedge ref_clk) disable iff (!rstn)
      spec_set[0] != crsd_pkg::CRSD_SET_NONE && spec_code[0] >= 3'h2
      |-> spec_idx[0] == {2'h0, spec_code[0]})
      else $error("codes 2 to 7 not passed through");
   a_wide_pass: assert property ( // [RULE4]
      @(posedge ref_clk) disable iff (!rstn)
      wide_spec_en && implicit_sel == crsd_pkg::CRSD_IMP_NONE
      |-> alt_valid && alt_idx == wide_spec)
      else $error("wide specifier not passed through");
   a_implicit_regs: assert property ( // [RULE5]
      @(posedge ref_clk) disable iff (!rstn)
      implicit_sel == crsd_pkg::CRSD_IMP_STACK_POINTER
      |-> alt_idx == 5'h1d && alt_valid)
      else $error("stack pointer index wrong");
   a_global_reg: assert property ( // [RULE5]
      @(posedge ref_clk) disable iff (!rstn)
      implicit_sel == crsd_pkg::CRSD_IMP_GLOBAL_POINTER
      |-> alt_valid && alt_idx == `CRSD_GPR_GLOBAL_POINTER)
      else $error("global pointer index wrong");
   a_return_reg: assert property ( // [RULE5]
      @(posedge ref_clk) disable iff (!rstn)
      implicit_sel == crsd_pkg::CRSD_IMP_RETURN_ADDRESS
      |-> alt_valid && alt_idx == `CRSD_GPR_RETURN_ADDRESS)
      else $error("return address index wrong");
   a_alt_idle: assert property ( // [RULE4]
      @(posedge ref_clk) disable iff (!rstn)
      implicit_sel == crsd_pkg::CRSD_IMP_NONE && !wide_spec_en
      |-> !alt_valid && alt_idx == `CRSD_GPR_ZERO)
      else $error("alternate index raised with nothing to name");
   a_pc_source: assert property ( // [RULE6]
      @(posedge ref_clk) disable iff (!rstn)
      pc_relative_add_immediate
      |-> src_kind == crsd_pkg::CRSD_SRC_PC)
      else $error("program counter not selected");
   a_muldiv_source: assert property ( // [RULE7]
      @(posedge ref_clk) disable iff (!rstn)
      !pc_relative_add_immediate && (move_from_upper ^ move_from_bottom)
      |-> src_kind == (move_from_upper ? crsd_pkg::CRSD_SRC_UPPER
                                       : crsd_pkg::CRSD_SRC_BOTTOM))
      else $error("mul/div word source wrong");
   a_gpr_source: assert property ( // [RULE7]
      @(posedge ref_clk) disable iff (!rstn)
      !pc_relative_add_immediate && !move_from_upper && !move_from_bottom
      |-> src_kind == crsd_pkg::CRSD_SRC_GPR)
      else $error("special source picked with no request");
   a_upper_first: assert property ( // [RULE7]
      @(posedge ref_clk) disable iff (!rstn)
      !pc_relative_add_immediate && move_from_upper && move_from_bottom
      |-> src_kind == crsd_pkg::CRSD_SRC_UPPER)
      else $error("upper word lost to bottom word");
   a_shift_range: assert property ( // [RULE8]
      @(posedge ref_clk) disable iff (!rstn)
      shift_amount != 4'h0 && shift_amount <= 4'h8
      && (shift_amount[2:0] == shift_code))
      else $error("shift amount out of range");
   a_shift_zero_code: assert property ( // [RULE8]
      @(posedge ref_clk) disable iff (!rstn)
      shift_code == `CRSD_SHAMT_ZERO_CODE
      |-> shift_amount == `CRSD_SHAMT_MAX)
      else $error("shift code zero not taken as eight");
   a_shift_small_codes: assert property ( // [RULE8]
      @(posedge ref_clk) disable iff (!rstn)
      shift_code != `CRSD_SHAMT_ZERO_CODE
      |-> shift_amount == {1'b0, shift_code})
      else $error("shift code not taken as its own amount");
   a_same_cycle: assert property ( // [RULE9]
      @(posedge ref_clk) disable iff (!rstn)
      s_shift_moved |-> s_amount_moved)
      else $error("decode lagged the instruction word");
   a_wide_same_cycle: assert property ( // [RULE9]
      @(posedge ref_clk) disable iff (!rstn)
      s_wide_moved |-> s_alt_moved)
      else $error("wide index lagged the instruction word");

   // same checks on every specifier port, not only the first
   genvar gc;
   generate
      for (gc = 0; gc < NUM_PORTS; gc++) begin : g_chk
         sequence s_code_moved;
            $changed(spec_code[gc]) && $stable(spec_set[gc]);
         endsequence
         sequence s_idx_moved;
            $changed(spec_idx[gc]);
         endsequence
         a_port_general: assert property ( // [RULE2]
            @(posedge ref_clk) disable iff (!rstn)
            spec_set[gc] == crsd_pkg::CRSD_SET_GENERAL
            && spec_code[gc] == 3'h0
            |-> spec_idx[gc] == `CRSD_GPR_S0)
            else $error("general set code zero mapped wrong");
         a_port_store_zero: assert property ( // [RULE3]
            @(posedge ref_clk) disable iff (!rstn)
            spec_set[gc] == crsd_pkg::CRSD_SET_STORE_SRC
            && spec_code[gc] == 3'h0
            |-> spec_idx[gc] == `CRSD_GPR_ZERO)
            else $error("store source code zero not the zero register");
         a_port_code_one: assert property ( // [RULE2]
            @(posedge ref_clk) disable iff (!rstn)
            spec_set[gc] != crsd_pkg::CRSD_SET_NONE && spec_code[gc] == 3'h1
            |-> spec_idx[gc] == `CRSD_GPR_S1)
            else $error("code one not mapped to register 17");
         a_port_high_codes: assert property ( // [RULE1]
            @(posedge ref_clk) disable iff (!rstn)
            spec_code[gc] >= 3'h2 || spec_set[gc] == crsd_pkg::CRSD_SET_NONE
            |-> spec_idx[gc] == {2'h0, spec_code[gc]})
            else $error("code not passed through unchanged");
         // each set maps codes one to one, so a code step moves the index
         a_port_same_cycle: assert property ( // [RULE9]
            @(posedge ref_clk) disable iff (!rstn)
            s_code_moved |-> s_idx_moved)
            else $error("specifier index lagged the instruction word");
      end
   endgenerate
endmodule

// *** crsd_regfile_model.sv ***
// register file read port model on the far side of the decoder
// assumes: index arrives combinationally from the decoder
`timescale 1ns/1ns
module crsd_regfile_model (
   input wire logic [4:0] rd_idx,
   output logic [31:0] rd_data
);
   // entry 0 reads as zero, others a pattern unique per index
   assign rd_data = (rd_idx == 5'h00) ? 32'h0
                                      : {27'h5a5a5a5, rd_idx};
endmodule

// *** tb_top.sv ***
// random and exhaustive checks of the compact register decoder
// assumes: decoder outputs are combinational and settle within 2 ns
`timescale 1ns/1ns
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin err_count++; \
$display("CHECK FAILED t=%0t got %h exp %h", $time, a, b); end end
module tb_top;
   logic ref_clk = 0, rstn = 0, wen = 0, pca = 0, mfu = 0, mfb = 0;
   logic [2:0] code [3] = '{3{3'h0}};
   crsd_pkg::crsd_set_type sets [3] = '{3{crsd_pkg::CRSD_SET_GENERAL}};
   crsd_pkg::crsd_imp_type imp = crsd_pkg::CRSD_IMP_NONE;
   crsd_pkg::crsd_src_type kind;
   logic [4:0] wide = 5'h00, idx [3], alt;
   logic [2:0] sh = 3'h0;
   logic [3:0] amt;
   logic valid;
   logic [31:0] rdat;
   int err_count = 0, checks = 0, cyc = 0;
   crsd_decoder u_dut (.ref_clk(ref_clk), .rstn(rstn), .spec_code(code),
      .spec_set(sets), .wide_spec(wide), .wide_spec_en(wen),
      .implicit_sel(imp), .pc_relative_add_immediate(pca),
      .move_from_upper(mfu), .move_from_bottom(mfb), .shift_code(sh),
      .spec_idx(idx), .alt_idx(alt), .alt_valid(valid), .src_kind(kind),
      .shift_amount(amt));
   crsd_regfile_model u_rf (.rd_idx(idx[0]), .rd_data(rdat));
   initial forever #4 ref_clk = ~ref_clk;
   // about 920 words are applied, one a cycle; 2000 leaves ample room
   always @(posedge ref_clk) begin
      cyc++;
      if (cyc > 2000) begin
         err_count++;
         test_done;
      end
   end
   function automatic logic [4:0] e_idx(logic [2:0] c, logic [1:0] s);
      if (c > 3'h1 || s == 2'h2) return {2'h0, c};
      if (c == 3'h1) return 5'h11;
      return (s == 2'h0) ? 5'h10 : 5'h00;
   endfunction
   function automatic logic [5:0] e_alt();
      if (imp != crsd_pkg::CRSD_IMP_NONE)
         return {1'b1, imp == 3'h1 ? 5'h1c : imp == 3'h2 ? 5'h1d : 5'h1f};
      return wen ? {1'b1, wide} : 6'h00;
   endfunction
   // far-side read of an index: the zero register reads as zero
   function automatic logic [31:0] e_rd(logic [4:0] i);
      return (i == 5'h00) ? 32'h0 : {27'h5a5a5a5, i};
   endfunction
   function automatic logic [1:0] e_src();
      return pca ? 2'h1 : mfu ? 2'h2 : mfb ? 2'h3 : 2'h0;
   endfunction
   task automatic apply(logic [15:0] v);
      @(negedge ref_clk);
      for (int p = 0; p < 3; p++) begin
         code[p] = v[2:0] + 3'(p);
         sets[p] = crsd_pkg::crsd_set_type'((v[4:3] + 2'(p)) % 3);
      end
      imp = crsd_pkg::crsd_imp_type'({1'b0, v[6:5]});
      {wen, pca, mfu, mfb} = v[10:7];
      wide = v[15:11];
      sh = v[13:11];
      #2;
      for (int p = 0; p < 3; p++)
         `CHK(idx[p], e_idx(code[p], sets[p]))
      `CHK(rdat, e_rd(e_idx(code[0], sets[0])))
      `CHK({valid, alt}, e_alt())
      `CHK(kind, e_src())
      `CHK(amt, (sh == 3'h0) ? 4'h8 : {1'b0, sh})
   endtask
   task automatic test_done;
      $display("counts: checks %0d mismatches %0d", checks, err_count);
      if (err_count == 0 && checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   initial begin
      void'($urandom(32'h0a5dd83d));
      repeat (3) @(posedge ref_clk);
      @(negedge ref_clk) rstn = 1;
      // codes, sets, implicit picks and source flags; wide and shift stay 0
      for (int i = 0; i < 2048; i += 3) apply(16'(i));
      $display("test exhaustive done");
      // every wide index and shift code, wide path enabled, no implicit
      for (int s = 0; s < 32; s++) apply(16'(s << 11) | 16'h0400);
      $display("test corner done");
      repeat (200) apply(16'($urandom));
      $display("test random done");
      test_done;
   end
endmodule
